/* rtl/dcl_dac_control.sv */
`timescale 1ns/100ps
// Contract
// - enable bit turns converter on and off
// - enabled: data write starts conversion immediately
// - disabled: data write waits for enable
// - enabled output always offered internally
// - run in standby keeps converter working while clk_per_available is high
// - no run in standby: standby stops all
// - wake re-enables after start-up delay
// - power-down always switches everything off
// - buffer bit drives the external pin
// - only first instance has a pin driver
// - control register layout and reset zero
// - eight-bit code register, reset zero
// - debug mode leaves behaviour unchanged
module dcl_dac_control
  import dcl_pkg::*;
#(
  parameter int INSTANCE_INDEX = 0
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [DCL_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [DCL_BUS_W-1:0]  avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [DCL_BUS_W-1:0]       avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  sleep_standby,
  input  wire logic                  sleep_power_down,
  input  wire logic                  clk_per_available,
  output dcl_conv_t                  conv,
  output logic                       core_on,
  output logic                       internal_out_valid,
  output logic                       pin_buffer_on
);

  localparam bit HAS_PIN = (INSTANCE_INDEX == 0);

  dcl_ctrl_t             ctrl_r;
  logic [DCL_DATA_W-1:0] code_r;
  dcl_state_t            state_r;
  dcl_state_t            state_nxt;
  logic                  pending_r;
  logic                  startup_done;
  logic                  startup_go;

  logic [1:0] idx;
  logic       req;
  logic       accept;
  logic       wr_ctrl;
  logic       wr_code;
  logic       hit;
  logic       suspend;
  logic       start_now;

  assign idx     = avs_address[DCL_IDX_LSB +: 2];
  assign hit     = (avs_address[DCL_IDX_LSB-1:0] == 2'h0) && (avs_address[DCL_ADDR_W-1] == 1'b0) &&
                   ((idx == DCL_IDX_CONVERTER_CONTROL) || (idx == DCL_IDX_CONVERTER_CODE));
  assign req     = avs_read || avs_write;
  assign accept  = req && !avs_waitrequest;
  assign wr_ctrl = accept && avs_write && hit && avs_byteenable[0] && (idx == DCL_IDX_CONVERTER_CONTROL);
  assign wr_code = accept && avs_write && hit && avs_byteenable[0] && (idx == DCL_IDX_CONVERTER_CODE);

  // waitrequest drops for exactly one cycle, one cycle after a request shows up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  // read data prepared the cycle before the accepting edge; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= DCL_READ_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      if (hit && idx == DCL_IDX_CONVERTER_CONTROL) begin
        avs_readdata <= {24'h000000, ctrl_r.run_in_standby, ctrl_r.output_buffer_enable, 5'h00, ctrl_r.enable};
      end else if (hit && idx == DCL_IDX_CONVERTER_CODE) begin
        avs_readdata <= {24'h000000, code_r};
      end else begin
        avs_readdata <= DCL_READ_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= DCL_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r.run_in_standby       <= avs_writedata[DCL_BIT_RUN_IN_STANDBY];
      ctrl_r.output_buffer_enable <= avs_writedata[DCL_BIT_OUTPUT_BUFFER_ENABLE];
      ctrl_r.unused               <= 5'h00;
      ctrl_r.enable               <= avs_writedata[DCL_BIT_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_r <= DCL_CODE_RESET;
    end else if (wr_code) begin
      code_r <= avs_writedata[DCL_DATA_W-1:0];
    end
  end

  // sleep inputs come from the power manager on this clock; debug has no input
  // at all, so halting the core cannot disturb the converter
  assign suspend = sleep_power_down ||
                   (sleep_standby && !(ctrl_r.run_in_standby && clk_per_available));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DCL_ST_OFF: begin
        if (ctrl_r.enable) begin
          state_nxt = suspend ? DCL_ST_SUSPENDED : DCL_ST_ACTIVE;
        end
      end
      DCL_ST_ACTIVE: begin
        if (!ctrl_r.enable) begin
          state_nxt = DCL_ST_OFF;
        end else if (suspend) begin
          state_nxt = DCL_ST_SUSPENDED;
        end
      end
      DCL_ST_SUSPENDED: begin
        if (!ctrl_r.enable) begin
          state_nxt = DCL_ST_OFF;
        end else if (!suspend) begin
          state_nxt = DCL_ST_STARTUP;
        end
      end
      DCL_ST_STARTUP: begin
        if (!ctrl_r.enable) begin
          state_nxt = DCL_ST_OFF;
        end else if (suspend) begin
          state_nxt = DCL_ST_SUSPENDED;
        end else if (startup_done) begin
          state_nxt = DCL_ST_ACTIVE;
        end
      end
      default: begin
        state_nxt = DCL_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= DCL_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign startup_go = (state_r == DCL_ST_SUSPENDED) && (state_nxt == DCL_ST_STARTUP);

  dcl_startup_timer #(
    .CYCLES (STARTUP_CYCLES)
  ) u_startup (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (startup_go),
    .abort   (state_r != DCL_ST_STARTUP && !startup_go),
    .done    (startup_done)
  );

  // a code written while the core cannot convert is held until it can;
  // a restart after wake always re-drives the current code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_r <= 1'b0;
    end else if (start_now) begin
      pending_r <= 1'b0;
    end else if (wr_code) begin
      pending_r <= 1'b1;
    end
  end

  assign start_now = (state_r == DCL_ST_ACTIVE && ctrl_r.enable && !suspend && wr_code) ||
                     (state_r == DCL_ST_OFF && ctrl_r.enable && !suspend) ||
                     (state_r == DCL_ST_STARTUP && startup_done && !suspend && ctrl_r.enable);

  // strobe carries the code that is current at trigger time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv <= '{start: 1'b0, code: DCL_CODE_RESET};
    end else begin
      conv.start <= start_now;
      if (start_now) begin
        conv.code <= wr_code ? avs_writedata[DCL_DATA_W-1:0] : code_r;
      end
    end
  end

  // analog power and routing follow the next state so they align with the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_on            <= 1'b0;
      internal_out_valid <= 1'b0;
      pin_buffer_on      <= 1'b0;
    end else begin
      core_on            <= (state_nxt == DCL_ST_ACTIVE) || (state_nxt == DCL_ST_STARTUP);
      internal_out_valid <= (state_nxt == DCL_ST_ACTIVE);
      pin_buffer_on      <= HAS_PIN && ctrl_r.output_buffer_enable &&
                            ((state_nxt == DCL_ST_ACTIVE) || (state_nxt == DCL_ST_STARTUP));
    end
  end

endmodule // dcl_dac_control

/* rtl/dcl_pkg.sv */
package dcl_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [1:0] DCL_IDX_CONVERTER_CONTROL = 2'h0;
  localparam logic [1:0] DCL_IDX_CONVERTER_CODE    = 2'h1;
  localparam int         DCL_ADDR_W                = 4;
  localparam int         DCL_IDX_LSB               = 2;
  localparam int         DCL_DATA_W                = 8;
  localparam int         DCL_BUS_W                 = 32;

  // field positions of converter_control
  localparam int DCL_BIT_ENABLE               = 0;
  localparam int DCL_BIT_OUTPUT_BUFFER_ENABLE = 6;
  localparam int DCL_BIT_RUN_IN_STANDBY       = 7;

  typedef struct packed {
    logic       run_in_standby;
    logic       output_buffer_enable;
    logic [4:0] unused;
    logic       enable;
  } dcl_ctrl_t;

  localparam dcl_ctrl_t             DCL_CTRL_RESET  = '{run_in_standby: 1'b0, output_buffer_enable: 1'b0,
                                                        unused: 5'h00, enable: 1'b0};
  localparam logic [DCL_DATA_W-1:0] DCL_CODE_RESET  = 8'h00;
  localparam logic [DCL_BUS_W-1:0]  DCL_READ_ZERO   = 32'h0000_0000;

  // analog start-up after a standby stop
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STARTUP_TIME_NS = 1000;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CNT_W   = 8;

  // request toward the analog core
  typedef struct packed {
    logic                  start;
    logic [DCL_DATA_W-1:0] code;
  } dcl_conv_t;

  typedef enum logic [3:0] {
    DCL_ST_OFF       = 4'b0001,
    DCL_ST_ACTIVE    = 4'b0010,
    DCL_ST_SUSPENDED = 4'b0100,
    DCL_ST_STARTUP   = 4'b1000
  } dcl_state_t;

endpackage

/* rtl/dcl_startup_timer.sv */
`timescale 1ns/100ps
module dcl_startup_timer
  import dcl_pkg::*;
#(
  parameter int CYCLES = STARTUP_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);

  localparam logic [STARTUP_CNT_W-1:0] LOAD = STARTUP_CNT_W'(CYCLES - 1);
  localparam logic [STARTUP_CNT_W-1:0] ONE  = 8'h01;
  localparam logic [STARTUP_CNT_W-1:0] ZERO = 8'h00;

  logic [STARTUP_CNT_W-1:0] count_r;
  logic                     busy_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= ZERO;
      busy_r  <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy_r <= 1'b0;
      end else if (start) begin
        count_r <= LOAD;
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        if (count_r == ZERO) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end else begin
          count_r <= count_r - ONE;
        end
      end
    end
  end

endmodule // dcl_startup_timer

/* tb/dcl_chk.sv */
`timescale 1ns/100ps
module dcl_chk
  import dcl_pkg::*;
#(
  parameter int INSTANCE_INDEX = 0
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic [DCL_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [DCL_BUS_W-1:0]  avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [DCL_BUS_W-1:0]  avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  sleep_standby,
  input wire logic                  sleep_power_down,
  input wire logic                  clk_per_available,
  input wire dcl_conv_t             conv,
  input wire logic                  core_on,
  input wire logic                  internal_out_valid,
  input wire logic                  pin_buffer_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_code_acc;
    avs_write && !avs_waitrequest && avs_address == 4'h4 && avs_byteenable[0];
  endsequence
  sequence s_live;
    internal_out_valid && !sleep_standby && !sleep_power_down;
  endsequence
  sequence s_new_strobe;
    conv.start && conv.code == $past(avs_writedata[7:0]);
  endsequence
  a_code_strobe: assert property (s_code_acc ##0 s_live |=> s_new_strobe)
    else $error("no strobe with written code");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_read_high: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_pd_off: assert property (sleep_power_down |=> !core_on && !internal_out_valid && !pin_buffer_on)
    else $error("converter on in power-down");
  a_valid_on: assert property (internal_out_valid |-> core_on)
    else $error("output offered while off");
  a_pin_first: assert property (INSTANCE_INDEX != 0 |-> !pin_buffer_on)
    else $error("pin buffer on other instance");
  a_code_hold: assert property (!conv.start |-> $stable(conv.code))
    else $error("code moved without strobe");
  a_start_live: assert property (conv.start |-> core_on)
    else $error("strobe while unpowered");
endmodule // dcl_chk
bind dcl_dac_control dcl_chk #(.INSTANCE_INDEX(INSTANCE_INDEX)) u_chk (
  .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_standby(sleep_standby),
  .sleep_power_down(sleep_power_down), .clk_per_available(clk_per_available), .conv(conv),
  .core_on(core_on), .internal_out_valid(internal_out_valid), .pin_buffer_on(pin_buffer_on));

/* tb/dcl_core_model.sv */
`timescale 1ns/100ps
module dcl_core_model
  import dcl_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire dcl_conv_t conv,
  input  wire logic      core_on,
  output logic [7:0]     strobes,
  output logic [7:0]     level
);
  // a strobe into an unpowered core is lost, as in silicon
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobes <= 8'h00;
      level   <= 8'h00;
    end else if (conv.start && core_on) begin
      strobes <= strobes + 8'h01;
      level   <= conv.code;
    end
  end
endmodule // dcl_core_model

/* tb/dcl_dac_control_tb.sv */
`timescale 1ns/100ps
module dcl_dac_control_tb
  import dcl_pkg::*;
;
  logic        clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        stby = 1'b0, pdn = 1'b0, clkav = 1'b0;
  logic [3:0]  addr = 4'h0, be = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        wreq, core, ivalid, pin, core2, pin2;
  logic [7:0]  strobes, level, q;
  dcl_conv_t   conv;
  int          failures = 0, cmp_count = 0, cyc = 0;

  always #5 clk = ~clk;
  dcl_dac_control #(.INSTANCE_INDEX(0)) u_dut (.clk(clk), .reset_n(reset_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .sleep_standby(stby), .sleep_power_down(pdn), .clk_per_available(clkav),
    .conv(conv), .core_on(core), .internal_out_valid(ivalid), .pin_buffer_on(pin));
  // second instance has no pin driver
  dcl_dac_control #(.INSTANCE_INDEX(1)) u_dut2 (.clk(clk), .reset_n(reset_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(),
    .avs_waitrequest(), .sleep_standby(stby), .sleep_power_down(pdn), .clk_per_available(clkav),
    .conv(), .core_on(core2), .internal_out_valid(), .pin_buffer_on(pin2));
  dcl_core_model u_core (.clk(clk), .reset_n(reset_n), .conv(conv), .core_on(core),
    .strobes(strobes), .level(level));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // outputs are read right after the edge, before the design's updates land
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] e);
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= {24'h000000, d};
    be    <= e;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rr(input logic [3:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(nm, q, e);
  endtask
  task automatic strobe(input logic [7:0] n, input logic [7:0] c);
    repeat (3) @(posedge clk);
    chk("strobes", strobes, n);
    chk("level", level, c);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      stop_test;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rr(4'h0, 8'h00, "ctrl");
    rr(4'h4, 8'h00, "code");
    rr(4'h8, 8'h00, "unmapped");
    bus(1'b1, 4'h4, 8'h5a, 4'hf);
    strobe(8'h00, 8'h00);
    rr(4'h4, 8'h5a, "code");
    bus(1'b1, 4'h0, 8'h3e, 4'hf);
    rr(4'h0, 8'h00, "ctrl");
    $display("test registers done");
    bus(1'b1, 4'h0, 8'h41, 4'hf);
    strobe(8'h01, 8'h5a);
    chk("valid", ivalid, 1);
    chk("pin", pin, 1);
    chk("pin2", pin2, 0);
    rr(4'h0, 8'h41, "ctrl");
    bus(1'b1, 4'h4, 8'ha5, 4'hf);
    strobe(8'h02, 8'ha5);
    bus(1'b1, 4'h4, 8'h11, 4'he);
    strobe(8'h02, 8'ha5);
    $display("test enable done");
    stby <= 1'b1;
    repeat (3) @(posedge clk);
    chk("core", core, 0);
    chk("pin", pin, 0);
    bus(1'b1, 4'h4, 8'h3c, 4'hf);
    strobe(8'h02, 8'ha5);
    stby <= 1'b0;
    repeat (50) @(posedge clk);
    chk("strobes", strobes, 8'h02);
    strobe(8'h02, 8'ha5);
    repeat (70) @(posedge clk);
    strobe(8'h03, 8'h3c);
    chk("pin", pin, 1);
    $display("test standby stop done");
    bus(1'b1, 4'h0, 8'hc1, 4'hf);
    clkav <= 1'b1;
    stby  <= 1'b1;
    repeat (5) @(posedge clk);
    chk("core", core, 1);
    bus(1'b1, 4'h4, 8'h77, 4'hf);
    strobe(8'h04, 8'h77);
    clkav <= 1'b0;
    repeat (3) @(posedge clk);
    chk("core", core, 0);
    stby <= 1'b0;
    repeat (120) @(posedge clk);
    strobe(8'h05, 8'h77);
    $display("test run in standby done");
    clkav <= 1'b1;
    pdn   <= 1'b1;
    repeat (3) @(posedge clk);
    chk("core", core, 0);
    chk("core2", core2, 0);
    pdn <= 1'b0;
    repeat (120) @(posedge clk);
    bus(1'b1, 4'h0, 8'h00, 4'hf);
    repeat (3) @(posedge clk);
    chk("core", core, 0);
    chk("valid", ivalid, 0);
    $display("test power down done");
    stop_test;
  end
endmodule // dcl_dac_control_tb
